// File: common/scg_pkg.sv
// Constants for the sleep-mode clock gating control block.
// Assumes an APB master on pclk and gated units that honour clk enables.
// Summary of operation
// - A set gate bit clocks its unit; a clear bit leaves it unclocked.
// - Any access to an unclocked unit ends in a bus fault.
// - Sleep gate register at offset 0x110, reset value 0x00000040.
// - Bit 16 gates the converter unit, read-write, resets to zero.
// - Bits 9:8 pick converter rate: 1 is 250K, 0 is 125K, reset zero.
// - Bit 6 gates the hibernation unit, read-write, resets to one.
// - Bit 3 gates the watchdog, resets zero; access while gated faults.
// - Reserved bits read zero and ignore writes.
// - This register rules sleep; the run twin shares its layout, the deep-sleep twin lacks bits 9:8.
// - Sleep settings apply only while the auto gate select bit is set.
`default_nettype none
package scg_pkg;
   localparam logic [11:0] SCG_CFG_OFS = 12'h060;
   localparam logic [11:0] SCG_RUN_OFS = 12'h100;
   localparam logic [11:0] SCG_SLEEP_OFS = 12'h110;
   localparam logic [11:0] SCG_DEEP_OFS = 12'h120;
   localparam logic [11:0] SCG_STAT_OFS = 12'h1f0;
   localparam logic [31:0] SCG_GATE_RESET = 32'h0000_0040;
   localparam logic [31:0] SCG_GATE_WMASK = 32'h0001_0348;
   localparam logic [31:0] SCG_DEEP_WMASK = 32'h0001_0048;
   localparam logic [31:0] SCG_CFG_RESET = 32'h0000_0000;
   localparam int SCG_ACG_BIT = 27;
   localparam int SCG_ADC_BIT = 16;
   localparam int SCG_HIB_BIT = 6;
   localparam int SCG_WDT_BIT = 3;
   localparam int SCG_RATE_LSB = 8;
   localparam int SCG_MODE_LSB = 30;
   localparam int SCG_UNITS = 3;
   // Unit index 0 watchdog, 1 hibernation, 2 converter
   localparam int SCG_UNIT_BIT [0:2] = '{SCG_WDT_BIT, SCG_HIB_BIT,
                                        SCG_ADC_BIT};
   localparam logic [1:0] SCG_RATE_125K = 2'h0;
   localparam logic [1:0] SCG_RATE_250K = 2'h1;
   typedef enum logic [1:0] {
      SCG_MODE_RUN,
      SCG_MODE_SLEEP,
      SCG_MODE_DEEP
   } scg_mode_type;
endpackage : scg_pkg
`default_nettype wire

// File: rtl/scg_sleep_gate.sv
// Sleep-mode clock gating control with run and deep-sleep twins.
// Assumes sleep requests and unit access strobes come from pclk logic.
//
// Decided for this implementation: the APB slave port.
`default_nettype none
module scg_sleep_gate (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire logic sleep_req,
   input wire logic deep_sleep_req,
   input wire logic [2:0] unit_access,
   output logic [2:0] unit_clk_en,
   output logic [2:0] unit_bus_fault,
   output logic [1:0] converter_rate_select
);
   logic [31:0] run_gate_reg0;
   logic [31:0] sleep_gate_reg0;
   logic [31:0] deep_sleep_gate_reg0;
   logic [31:0] run_clock_config;
   scg_pkg::scg_mode_type mode;
   logic setup;
   logic access;
   logic mapped;
   logic [31:0] read_word;
   logic [31:0] next_gate;
   logic auto_gate_select;
   logic wr_run;
   logic wr_sleep;
   logic wr_deep;
   logic wr_cfg;

   assign auto_gate_select = run_clock_config[scg_pkg::SCG_ACG_BIT];

   // APB phases; pready is a flop loaded from setup, so no transfer waits
   assign setup = psel && !penable;
   assign access = psel && penable && pready;
   assign wr_run = access && pwrite && !pslverr &&
                   (paddr == scg_pkg::SCG_RUN_OFS);
   assign wr_sleep = access && pwrite && !pslverr &&
                     (paddr == scg_pkg::SCG_SLEEP_OFS);
   assign wr_deep = access && pwrite && !pslverr &&
                    (paddr == scg_pkg::SCG_DEEP_OFS);
   assign wr_cfg = access && pwrite && !pslverr &&
                   (paddr == scg_pkg::SCG_CFG_OFS);

   always_comb begin
      mapped = 1'b1;
      unique case (paddr)
         scg_pkg::SCG_RUN_OFS: read_word = run_gate_reg0;
         scg_pkg::SCG_SLEEP_OFS: read_word = sleep_gate_reg0;
         scg_pkg::SCG_DEEP_OFS: read_word = deep_sleep_gate_reg0;
         scg_pkg::SCG_CFG_OFS: read_word = run_clock_config;
         scg_pkg::SCG_STAT_OFS: begin
            read_word = next_gate;
            read_word[scg_pkg::SCG_MODE_LSB +: 2] = mode;
         end
         default: begin
            read_word = 32'h0000_0000;
            mapped = 1'b0;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= setup;
      end
   end

   // Read data and error are captured at setup and held over access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (setup) begin
         prdata <= pwrite ? 32'h0000_0000 : read_word;
         pslverr <= !mapped;
      end else if (!psel) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
   end

   // Reserved bits never load, so they stay zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sleep_gate_reg0 <= scg_pkg::SCG_GATE_RESET;
      end else if (wr_sleep) begin
         sleep_gate_reg0 <= pwdata & scg_pkg::SCG_GATE_WMASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_gate_reg0 <= scg_pkg::SCG_GATE_RESET;
      end else if (wr_run) begin
         run_gate_reg0 <= pwdata & scg_pkg::SCG_GATE_WMASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         deep_sleep_gate_reg0 <= scg_pkg::SCG_GATE_RESET;
      end else if (wr_deep) begin
         deep_sleep_gate_reg0 <= pwdata & scg_pkg::SCG_DEEP_WMASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_clock_config <= scg_pkg::SCG_CFG_RESET;
      end else if (wr_cfg) begin
         run_clock_config[scg_pkg::SCG_ACG_BIT] <=
            pwdata[scg_pkg::SCG_ACG_BIT];
      end
   end

   // Deep sleep outranks sleep when both are requested
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode <= scg_pkg::SCG_MODE_RUN;
      end else if (deep_sleep_req) begin
         mode <= scg_pkg::SCG_MODE_DEEP;
      end else if (sleep_req) begin
         mode <= scg_pkg::SCG_MODE_SLEEP;
      end else begin
         mode <= scg_pkg::SCG_MODE_RUN;
      end
   end

   // Without auto gate select the run settings govern every mode
   always_comb begin
      next_gate = run_gate_reg0;
      if (auto_gate_select) begin
         unique case (mode)
            scg_pkg::SCG_MODE_SLEEP: next_gate = sleep_gate_reg0;
            scg_pkg::SCG_MODE_DEEP: next_gate = deep_sleep_gate_reg0;
            scg_pkg::SCG_MODE_RUN: next_gate = run_gate_reg0;
            default: next_gate = run_gate_reg0;
         endcase
      end
   end

   // Enables leave flops so a downstream latch gate sees no glitch
   genvar u;
   generate
      for (u = 0; u < scg_pkg::SCG_UNITS; u++) begin : g_unit
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               unit_clk_en[u] <=
                  scg_pkg::SCG_GATE_RESET[scg_pkg::SCG_UNIT_BIT[u]];
            end else begin
               unit_clk_en[u] <= next_gate[scg_pkg::SCG_UNIT_BIT[u]];
            end
         end
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               unit_bus_fault[u] <= 1'b0;
            end else begin
               unit_bus_fault[u] <= unit_access[u] && !unit_clk_en[u];
            end
         end
      end
   endgenerate

   // Rate select is not range-checked; software keeps it legal
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         converter_rate_select <= scg_pkg::SCG_RATE_125K;
      end else begin
         converter_rate_select <= next_gate[scg_pkg::SCG_RATE_LSB +: 2];
      end
   end

   // Helper for the reset value check
   logic seen_clk;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seen_clk <= 1'b0;
      end else begin
         seen_clk <= 1'b1;
      end
   end

   chk_gate_follows_run: assert property (
      @(posedge pclk) disable iff (!presetn)
      mode == scg_pkg::SCG_MODE_RUN |=> unit_clk_en ==
         $past({run_gate_reg0[16], run_gate_reg0[6], run_gate_reg0[3]}))
      else $error("unit enables do not follow run gates");

   chk_fault_when_gated: assert property (
      @(posedge pclk) disable iff (!presetn)
      1'b1 |=> unit_bus_fault == $past(unit_access & ~unit_clk_en))
      else $error("bus fault does not match gated access");

   chk_reset_value: assert property (
      @(posedge pclk) disable iff (!presetn)
      !seen_clk |-> sleep_gate_reg0 == scg_pkg::SCG_GATE_RESET &&
         unit_clk_en == 3'h2)
      else $error("sleep gate reset value wrong");

   chk_adc_bit_write: assert property (
      @(posedge pclk) disable iff (!presetn)
      wr_sleep |=> sleep_gate_reg0[16] == $past(pwdata[16]))
      else $error("converter gate bit not written");

   chk_rate_sleep: assert property (
      @(posedge pclk) disable iff (!presetn)
      auto_gate_select && mode == scg_pkg::SCG_MODE_SLEEP |=>
         converter_rate_select == $past(sleep_gate_reg0[9:8]))
      else $error("rate select does not follow sleep field");

   chk_hib_bit_write: assert property (
      @(posedge pclk) disable iff (!presetn)
      wr_sleep |=> sleep_gate_reg0[6] == $past(pwdata[6]))
      else $error("hibernation gate bit not written");

   chk_wdt_fault: assert property (
      @(posedge pclk) disable iff (!presetn)
      unit_access[0] && !unit_clk_en[0] |=> unit_bus_fault[0])
      else $error("watchdog access while gated did not fault");

   chk_reserved_zero: assert property (
      @(posedge pclk) disable iff (!presetn)
      (sleep_gate_reg0 & ~scg_pkg::SCG_GATE_WMASK) == 32'h0000_0000)
      else $error("reserved sleep gate bits not zero");

   chk_deep_select: assert property (
      @(posedge pclk) disable iff (!presetn)
      auto_gate_select && mode == scg_pkg::SCG_MODE_DEEP |=>
         unit_clk_en[2] == $past(deep_sleep_gate_reg0[16]))
      else $error("deep sleep gates not applied");

   chk_sleep_select: assert property (
      @(posedge pclk) disable iff (!presetn)
      auto_gate_select && mode == scg_pkg::SCG_MODE_SLEEP |=>
         unit_clk_en == $past({sleep_gate_reg0[16], sleep_gate_reg0[6],
                               sleep_gate_reg0[3]}))
      else $error("sleep gates not applied");

   chk_no_auto_run: assert property (
      @(posedge pclk) disable iff (!presetn)
      !auto_gate_select && mode != scg_pkg::SCG_MODE_RUN |=>
         unit_clk_en[0] == $past(run_gate_reg0[3]))
      else $error("run gates not kept while sleeping");

   chk_write_latency: assert property (
      @(posedge pclk) disable iff (!presetn)
      wr_sleep && auto_gate_select && mode == scg_pkg::SCG_MODE_SLEEP
         ##1 mode == scg_pkg::SCG_MODE_SLEEP && auto_gate_select |=>
         unit_clk_en[2] == $past(pwdata[16], 2))
      else $error("gate change not applied one cycle after write");

   // Bus protocol, register, mode and rate checks
   chk_ready_pulse: assert property (
      @(posedge pclk) disable iff (!presetn)
      pready |=> !pready)
      else $error("ready held longer than one access cycle");

   chk_ready_after_setup: assert property (
      @(posedge pclk) disable iff (!presetn)
      psel && !penable |=> pready)
      else $error("ready missing after setup cycle");

   chk_unmapped_error: assert property (
      @(posedge pclk) disable iff (!presetn)
      psel && !penable && !mapped |=> pslverr)
      else $error("unmapped address did not raise slave error");

   chk_sleep_readback: assert property (
      @(posedge pclk) disable iff (!presetn)
      psel && !penable && !pwrite &&
         paddr == scg_pkg::SCG_SLEEP_OFS |=>
         prdata == $past(sleep_gate_reg0))
      else $error("sleep gate read data wrong");

   chk_wdt_bit_write: assert property (
      @(posedge pclk) disable iff (!presetn)
      wr_sleep |=> sleep_gate_reg0[3] == $past(pwdata[3]))
      else $error("watchdog gate bit not written");

   chk_rate_write: assert property (
      @(posedge pclk) disable iff (!presetn)
      wr_sleep |=> sleep_gate_reg0[9:8] == $past(pwdata[9:8]))
      else $error("rate field not written");

   chk_run_reserved: assert property (
      @(posedge pclk) disable iff (!presetn)
      (run_gate_reg0 & ~scg_pkg::SCG_GATE_WMASK) == 32'h0000_0000)
      else $error("reserved run gate bits not zero");

   chk_deep_reserved: assert property (
      @(posedge pclk) disable iff (!presetn)
      (deep_sleep_gate_reg0 & ~scg_pkg::SCG_DEEP_WMASK) == 32'h0000_0000)
      else $error("reserved deep gate bits not zero");

   chk_rate_no_auto: assert property (
      @(posedge pclk) disable iff (!presetn)
      !auto_gate_select |=>
         converter_rate_select == $past(run_gate_reg0[9:8]))
      else $error("rate does not follow run field");

   chk_deep_wins: assert property (
      @(posedge pclk) disable iff (!presetn)
      deep_sleep_req |=> mode == scg_pkg::SCG_MODE_DEEP)
      else $error("deep sleep request not taken");

   chk_sleep_hold: assert property (
      @(posedge pclk) disable iff (!presetn)
      !wr_sleep |=> sleep_gate_reg0 == $past(sleep_gate_reg0))
      else $error("sleep gate register changed without a write");

   chk_cfg_reserved: assert property (
      @(posedge pclk) disable iff (!presetn)
      (run_clock_config & ~(32'h0000_0001 << scg_pkg::SCG_ACG_BIT)) ==
         32'h0000_0000)
      else $error("reserved config bits not zero");

   chk_rate_deep: assert property (
      @(posedge pclk) disable iff (!presetn)
      auto_gate_select && mode == scg_pkg::SCG_MODE_DEEP |=>
         converter_rate_select == scg_pkg::SCG_RATE_125K)
      else $error("deep sleep rate not at reset speed");

   cov_sleep_auto: cover property (
      @(posedge pclk) disable iff (!presetn)
      auto_gate_select && mode == scg_pkg::SCG_MODE_SLEEP);
   cov_deep_auto: cover property (
      @(posedge pclk) disable iff (!presetn)
      auto_gate_select && mode == scg_pkg::SCG_MODE_DEEP);
   cov_fault: cover property (
      @(posedge pclk) disable iff (!presetn)
      unit_bus_fault[2]);
   cov_rate_fast: cover property (
      @(posedge pclk) disable iff (!presetn)
      converter_rate_select == scg_pkg::SCG_RATE_250K);
   cov_write_in_sleep: cover property (
      @(posedge pclk) disable iff (!presetn)
      wr_sleep && auto_gate_select && mode == scg_pkg::SCG_MODE_SLEEP);
endmodule : scg_sleep_gate
`default_nettype wire

// File: tb/scg_unit_model.sv
// Fabric and gated units seen from the far side of the gating block.
// Assumes the bench raises access strobes just after a pclk edge.
`default_nettype none
module scg_unit_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [2:0] access_req,
   input wire logic [2:0] unit_bus_fault,
   output logic [2:0] unit_access,
   output logic [2:0] fault_seen
);
   timeunit 1ns;
   timeprecision 1ps;
   // Any unit may be hit, clocked or not
   assign unit_access = access_req;
   // Latched, so a one-cycle fault is not missed
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fault_seen <= 3'h0;
      end else begin
         fault_seen <= fault_seen | unit_bus_fault;
      end
   end
endmodule : scg_unit_model
`default_nettype wire

// File: tb/test_sleep_clock_gating_control.sv
// Self-checking bench for the sleep-mode clock gating block.
// Assumes one 50 MHz clock and the unit model on the fabric side.
`default_nettype none
module test_sleep_clock_gating_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0000_0000;
   logic pready, pslverr, err;
   logic [31:0] prdata, rd;
   logic sleep_req = 1'b0;
   logic deep_sleep_req = 1'b0;
   logic [2:0] access_req = 3'h0;
   logic [2:0] unit_access, unit_clk_en, unit_bus_fault, fault_seen;
   logic [1:0] converter_rate_select;
   int errors = 0;
   int comparisons = 0;

   always #10 pclk = ~pclk;

   scg_sleep_gate scg_sleep_gate_inst (.pclk(pclk), .presetn(presetn),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .sleep_req(sleep_req),
      .deep_sleep_req(deep_sleep_req), .unit_access(unit_access),
      .unit_clk_en(unit_clk_en), .unit_bus_fault(unit_bus_fault),
      .converter_rate_select(converter_rate_select));

   scg_unit_model scg_unit_model_inst (.pclk(pclk), .presetn(presetn),
      .access_req(access_req), .unit_bus_fault(unit_bus_fault),
      .unit_access(unit_access), .fault_seen(fault_seen));

   task results;
      if (errors == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : results

   task check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // Waits on pready itself; slave latency is not assumed
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= wr;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) errors++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Mode requests go through the mode flop and then the enable flop, hence two edges
   task set_mode(input logic slp, input logic deep);
      @(posedge pclk);
      sleep_req <= slp;
      deep_sleep_req <= deep;
      repeat (2) @(posedge pclk);
      #1;
   endtask : set_mode

   task probe(input int unit, input logic exp);
      @(posedge pclk);
      access_req <= 3'b001 << unit;
      @(posedge pclk);
      access_req <= 3'h0;
      #1 check({31'h0, unit_bus_fault[unit]}, {31'h0, exp});
   endtask : probe

   task t_reset;
      check({29'h0, unit_clk_en}, 32'h0000_0002);
      check({30'h0, converter_rate_select}, 32'h0);
      apb(1'b0, scg_pkg::SCG_SLEEP_OFS, 32'h0);
      check(rd, 32'h0000_0040);
   endtask : t_reset

   task t_regs;
      apb(1'b1, scg_pkg::SCG_SLEEP_OFS, 32'hffff_fdff);
      apb(1'b0, scg_pkg::SCG_SLEEP_OFS, 32'h0);
      check(rd, 32'h0001_0148);
      // Read-modify-write keeps reserved bits as read
      apb(1'b1, scg_pkg::SCG_SLEEP_OFS, rd & 32'hffff_febf);
      apb(1'b0, scg_pkg::SCG_SLEEP_OFS, 32'h0);
      check(rd, 32'h0001_0008);
      apb(1'b1, 12'h114, 32'hffff_ffff);
      check({31'h0, err}, 32'h1);
      apb(1'b0, scg_pkg::SCG_SLEEP_OFS, 32'h0);
      check(rd, 32'h0001_0008);
      check({31'h0, err}, 32'h0);
      apb(1'b1, scg_pkg::SCG_DEEP_OFS, 32'hffff_fdff);
      apb(1'b0, scg_pkg::SCG_DEEP_OFS, 32'h0);
      check(rd, 32'h0001_0048);
      apb(1'b1, scg_pkg::SCG_RUN_OFS, 32'hffff_fdff);
      @(posedge pclk);
      #1 check({29'h0, unit_clk_en}, 32'h0000_0007);
      check({30'h0, converter_rate_select}, 32'h1);
      apb(1'b1, scg_pkg::SCG_RUN_OFS, 32'h0000_0040);
      apb(1'b0, scg_pkg::SCG_RUN_OFS, 32'h0);
      check(rd, 32'h0000_0040);
   endtask : t_regs

   task t_modes;
      // Only rate 0 or 1 is ever programmed
      apb(1'b1, scg_pkg::SCG_SLEEP_OFS, 32'h0001_0108);
      set_mode(1'b1, 1'b0);
      check({29'h0, unit_clk_en}, 32'h0000_0002);
      check({30'h0, converter_rate_select}, 32'h0);
      apb(1'b1, scg_pkg::SCG_CFG_OFS, 32'h0800_0000);
      @(posedge pclk);
      #1 check({29'h0, unit_clk_en}, 32'h0000_0005);
      check({30'h0, converter_rate_select}, 32'h1);
      apb(1'b0, scg_pkg::SCG_STAT_OFS, 32'h0);
      check(rd, 32'h4001_0108);
      apb(1'b1, scg_pkg::SCG_SLEEP_OFS, 32'h0000_0048);
      #1 check({29'h0, unit_clk_en}, 32'h0000_0005);
      @(posedge pclk);
      #1 check({29'h0, unit_clk_en}, 32'h0000_0003);
      check({30'h0, converter_rate_select}, 32'h0);
      apb(1'b1, scg_pkg::SCG_SLEEP_OFS, 32'h0001_0108);
      set_mode(1'b1, 1'b1);
      check({29'h0, unit_clk_en}, 32'h0000_0007);
      check({30'h0, converter_rate_select}, 32'h0);
      set_mode(1'b1, 1'b0);
      check({29'h0, unit_clk_en}, 32'h0000_0005);
   endtask : t_modes

   task t_faults;
      probe(1, 1'b1);
      probe(0, 1'b0);
      probe(2, 1'b0);
      set_mode(1'b0, 1'b0);
      probe(0, 1'b1);
      probe(2, 1'b1);
      @(posedge pclk);
      #1 check({29'h0, fault_seen}, 32'h0000_0007);
   endtask : t_faults

   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      #1;
      t_reset();
      t_regs();
      t_modes();
      t_faults();
      results();
   end

   // Whole run is under a hundred cycles; this is far beyond it
   initial begin
      #100us;
      errors++;
      results();
   end
endmodule : test_sleep_clock_gating_control
`default_nettype wire
